// File: rtl/pts_cfg.svh
// Purpose: constants for the pcm time-slot port
// Assumes: bit clock supplied by the highway logic
// Notes: widths fixed
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH
`define PTS_WORD_BITS 8
`define PTS_CNT_W 4
`define PTS_LAST_BIT 4'h7
`define PTS_IDLE_BYTE 8'hFF
`define PTS_BCLK_MIN_KHZ 64
`define PTS_BCLK_MAX_KHZ 4096
`define PTS_BCLK_STEP_KHZ 8
`endif

// File: rtl/pts_pkg.sv
// Purpose: types for the pcm time-slot port
// Assumes: nothing
// Notes: none
package pts_pkg;
   typedef logic [7:0] pts_byte_type;
endpackage : pts_pkg

// File: rtl/pts_port.sv
// Purpose: serial pcm time-slot port, one byte each way per frame
// Assumes: bit clock and syncs from the highway logic
// Notes: link side runs on the bit clock
// Behaviour
// RULE1: transmit bits change after the rising bit-clock edge
// RULE2: receive data sampled on falling bit-clock edge; far end holds it
// RULE3: frame syncs sampled on falling bit-clock edges
// RULE4: transmit output released after eighth bit, by three end conditions
// RULE5: slot indicator low while bit clock and transmit sync both high; in delayed mode it goes low only when tx_act_ff sets
// RULE6: slot indicator released under the same three end conditions
// RULE7: non-delayed mode, late sync rise launches first bit itself
// RULE8: bit clock 64 kHz to 4.096 MHz in 8 kHz steps, far end; the bench highway drives a 6 ns bit clock
// RULE9: delayed and non-delayed short-frame timing both supported
`timescale 1ns/1ps
`include "pts_cfg.svh"
module pts_port (
   input wire logic CLOCK_IN,
   input wire logic NRST_IN,
   input wire logic BIT_CLOCK_IN,
   input wire logic TRANSMIT_FRAME_SYNC_IN,
   input wire logic RECEIVE_FRAME_SYNC_IN,
   input wire logic PCM_RECEIVE_INPUT_IN,
   input wire logic DELAYED_MODE_IN,
   input wire logic [7:0] TX_WORD_IN,
   output logic PCM_TRANSMIT_OUTPUT_OUT,
   output logic PCM_TRANSMIT_OE_OUT,
   output logic TRANSMIT_SLOT_INDICATOR_N_OUT,
   output pts_pkg::pts_byte_type RX_WORD_OUT,
   output logic RX_VALID_OUT
);
   import pts_pkg::*;
   ////////////////////////////////////////////////////////////////////
   // link-domain reset: sync system reset onto bit clock
   logic lrst_n;
   pts_sync2 u_lrst (
      .clk_in(BIT_CLOCK_IN),
      .nrst_in(NRST_IN),
      .d_in(1'b1),
      .q_out(lrst_n)
   );
   logic mode_l;
   pts_sync2 u_mode (
      .clk_in(BIT_CLOCK_IN),
      .nrst_in(NRST_IN),
      .d_in(DELAYED_MODE_IN),
      .q_out(mode_l)
   );
   ////////////////////////////////////////////////////////////////////
   // falling-edge sampling of syncs and receive data
   logic fsx_s_ff, fsr_s_ff, dr_s_ff;
   always_ff @(negedge BIT_CLOCK_IN) begin
      fsx_s_ff <= TRANSMIT_FRAME_SYNC_IN; // see RULE3
      fsr_s_ff <= RECEIVE_FRAME_SYNC_IN; // see RULE3
      dr_s_ff <= PCM_RECEIVE_INPUT_IN; // see RULE2
   end
   ////////////////////////////////////////////////////////////////////
   // transmit: shift on rising edge, count bits
   logic tx_act_ff, nxt_tx_act;
   logic [3:0] tx_cnt_ff, nxt_tx_cnt;
   pts_byte_type tx_sh_ff, nxt_tx_sh;
   logic fsx_prev_ff;
   logic [7:0] tx_word_l;
   always_comb begin
      nxt_tx_act = tx_act_ff;
      nxt_tx_cnt = tx_cnt_ff;
      nxt_tx_sh = tx_sh_ff;
      if (fsx_s_ff && !fsx_prev_ff && !tx_act_ff) begin
         // see RULE9: delayed mode holds first bit one edge
         nxt_tx_act = 1'b1;
         nxt_tx_cnt = mode_l ? 4'h0 : 4'h1;
         nxt_tx_sh = mode_l ? tx_word_l : {tx_word_l[6:0], 1'b0};
      end else if (tx_act_ff) begin
         nxt_tx_sh = {tx_sh_ff[6:0], 1'b0}; // see RULE1
         nxt_tx_cnt = 4'(tx_cnt_ff + 4'h1);
         // count sits at the last index while the eighth bit is out
         if (tx_cnt_ff == `PTS_LAST_BIT) begin
            nxt_tx_act = 1'b0; // see RULE4
         end
      end
   end
   always_ff @(posedge BIT_CLOCK_IN) begin
      if (!lrst_n) begin
         tx_act_ff <= 1'b0;
         tx_cnt_ff <= 4'h0;
         tx_sh_ff <= `PTS_IDLE_BYTE;
         fsx_prev_ff <= 1'b0;
      end else begin
         tx_act_ff <= nxt_tx_act;
         tx_cnt_ff <= nxt_tx_cnt;
         tx_sh_ff <= nxt_tx_sh;
         fsx_prev_ff <= fsx_s_ff;
      end
   end
   // word registered in system domain on every system clock; stable at use
   logic [7:0] tx_hold_ff;
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) tx_hold_ff <= `PTS_IDLE_BYTE;
      else tx_hold_ff <= TX_WORD_IN;
   end
   assign tx_word_l = tx_hold_ff;
   ////////////////////////////////////////////////////////////////////
   // end of slot: eighth falling edge with sync low, later sync fall
   // falling-edge flag lets a late sync fall end the slot mid-bit
   logic end_fall_ff;
   always_ff @(negedge BIT_CLOCK_IN) begin
      end_fall_ff <= tx_act_ff && (tx_cnt_ff == `PTS_LAST_BIT); // see RULE4
   end
   // see RULE5 see RULE6: drive combinationally at link pins
   logic slot_on;
   assign slot_on = lrst_n && tx_act_ff
      && !(end_fall_ff && !TRANSMIT_FRAME_SYNC_IN);
   // first bit stands from sync and clock high until the shifter takes over
   logic first_bit;
   assign first_bit = lrst_n && !mode_l && !tx_act_ff // see RULE7
      && ((TRANSMIT_FRAME_SYNC_IN && BIT_CLOCK_IN && !fsx_s_ff)
      || (fsx_s_ff && !fsx_prev_ff));
   ////////////////////////////////////////////////////////////////////
   // receive: sample on falling edge, shift on rising edge after sync seen
   logic rx_act_ff, nxt_rx_act;
   logic [3:0] rx_cnt_ff, nxt_rx_cnt;
   pts_byte_type rx_sh_ff, nxt_rx_sh, rx_word_ff, nxt_rx_word;
   logic rx_tog_ff, nxt_rx_tog;
   always_comb begin
      nxt_rx_act = rx_act_ff;
      nxt_rx_cnt = rx_cnt_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_word = rx_word_ff;
      nxt_rx_tog = rx_tog_ff;
      if (!rx_act_ff && fsr_s_ff) begin
         nxt_rx_act = 1'b1;
         // non-delayed: first bit shares the sync edge; delayed shifts it out
         nxt_rx_cnt = mode_l ? 4'h0 : 4'h1; // see RULE9
         nxt_rx_sh = {rx_sh_ff[6:0], dr_s_ff}; // see RULE2
      end else if (rx_act_ff) begin
         nxt_rx_sh = {rx_sh_ff[6:0], dr_s_ff}; // see RULE2
         nxt_rx_cnt = 4'(rx_cnt_ff + 4'h1);
         if (rx_cnt_ff == `PTS_LAST_BIT) begin
            nxt_rx_act = 1'b0;
            nxt_rx_word = {rx_sh_ff[6:0], dr_s_ff};
            nxt_rx_tog = ~rx_tog_ff;
         end
      end
   end
   always_ff @(posedge BIT_CLOCK_IN) begin
      if (!lrst_n) begin
         rx_act_ff <= 1'b0;
         rx_cnt_ff <= 4'h0;
         rx_sh_ff <= 8'h00;
         rx_word_ff <= 8'h00;
         rx_tog_ff <= 1'b0;
      end else begin
         rx_act_ff <= nxt_rx_act;
         rx_cnt_ff <= nxt_rx_cnt;
         rx_sh_ff <= nxt_rx_sh;
         rx_word_ff <= nxt_rx_word;
         rx_tog_ff <= nxt_rx_tog;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // toggle crossing of received word into system clock
   logic rx_tog_s, rx_tog_d_ff;
   pts_sync2 u_rxt (
      .clk_in(CLOCK_IN),
      .nrst_in(NRST_IN),
      .d_in(rx_tog_ff),
      .q_out(rx_tog_s)
   );
   pts_byte_type rx_out_ff;
   logic rx_vld_ff;
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) begin
         rx_tog_d_ff <= 1'b0;
         rx_out_ff <= 8'h00;
         rx_vld_ff <= 1'b0;
      end else begin
         rx_tog_d_ff <= rx_tog_s;
         rx_vld_ff <= rx_tog_s ^ rx_tog_d_ff;
         if (rx_tog_s ^ rx_tog_d_ff) rx_out_ff <= rx_word_ff;
      end
   end
   assign RX_WORD_OUT = rx_out_ff;
   assign RX_VALID_OUT = rx_vld_ff;
   // pin outputs: timing relative to bit clock demands pin-level gating
   assign PCM_TRANSMIT_OE_OUT = slot_on || first_bit; // see RULE4
   assign PCM_TRANSMIT_OUTPUT_OUT = first_bit ? tx_word_l[7] : tx_sh_ff[7];
   assign TRANSMIT_SLOT_INDICATOR_N_OUT = !(slot_on || first_bit);
   ////////////////////////////////////////////////////////////////////
   a_rx_valid_pulse: assert property (@(posedge CLOCK_IN) // see RULE2
      disable iff (!NRST_IN) RX_VALID_OUT |=> !RX_VALID_OUT)
      else $error("receive valid longer than one cycle");
   a_tx_bit_count: assert property (@(posedge BIT_CLOCK_IN) // see RULE4
      disable iff (!lrst_n) tx_act_ff |-> tx_cnt_ff <= `PTS_LAST_BIT)
      else $error("transmit count past eight");
   a_tx_release: assert property (@(posedge BIT_CLOCK_IN) // see RULE6
      disable iff (!lrst_n)
      (tx_act_ff && tx_cnt_ff == `PTS_LAST_BIT) |=> !tx_act_ff)
      else $error("slot not released");
   a_slot_match: assert property (@(posedge BIT_CLOCK_IN) // see RULE5
      disable iff (!lrst_n)
      PCM_TRANSMIT_OE_OUT == !TRANSMIT_SLOT_INDICATOR_N_OUT)
      else $error("indicator and enable disagree");
   a_rx_count: assert property (@(negedge BIT_CLOCK_IN) // see RULE3
      disable iff (!lrst_n) rx_act_ff |-> rx_cnt_ff <= `PTS_LAST_BIT)
      else $error("receive count overflow");
   a_delayed_start: assert property (@(posedge BIT_CLOCK_IN) // see RULE9
      disable iff (!lrst_n) ($rose(tx_act_ff) && mode_l) |-> tx_cnt_ff == 0)
      else $error("delayed start count wrong");
   a_nodelay_start: assert property (@(posedge BIT_CLOCK_IN) // see RULE7
      disable iff (!lrst_n) ($rose(tx_act_ff) && !mode_l) |-> tx_cnt_ff == 1)
      else $error("non-delayed start count wrong");
   a_tx_shift: assert property (@(posedge BIT_CLOCK_IN) // see RULE1
      disable iff (!lrst_n) (tx_act_ff && $past(tx_act_ff))
      |-> tx_sh_ff[0] == 1'b0)
      else $error("shift fill wrong");
   a_oe_reset: assert property (@(posedge BIT_CLOCK_IN) // see RULE4
      !lrst_n |-> !PCM_TRANSMIT_OE_OUT)
      else $error("transmit pin driven in reset");
   a_ind_release: assert property (@(negedge BIT_CLOCK_IN) // see RULE6
      disable iff (!lrst_n) (end_fall_ff && !TRANSMIT_FRAME_SYNC_IN)
      |-> TRANSMIT_SLOT_INDICATOR_N_OUT) else $error("indicator held");
   a_idle_quiet: assert property (@(posedge BIT_CLOCK_IN) // see RULE4
      disable iff (!lrst_n) (!tx_act_ff && !fsx_s_ff && !TRANSMIT_FRAME_SYNC_IN)
      |-> !PCM_TRANSMIT_OE_OUT) else $error("transmit pin driven idle");
endmodule : pts_port

// File: rtl/pts_sync2.sv
// Purpose: two-stage synchroniser for one level
// Assumes: destination clock free running
// Notes: first stage read only by second
`timescale 1ns/1ps
module pts_sync2 (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta_ff;
   logic q_ff;
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         meta_ff <= 1'b0;
         q_ff <= 1'b0;
      end else begin
         meta_ff <= d_in;
         q_ff <= meta_ff;
      end
   end
   assign q_out = q_ff;
endmodule : pts_sync2

// File: sim/pts_highway.sv
// Purpose: highway side model: bit clock, frame syncs, receive data
// Assumes: bit clock runs only within frames
// Notes: 6 ns bit clock, faster than a real highway, keeps the run short
`timescale 1ns/1ps
module pts_highway (
   output logic bclk_out,
   output logic fsx_out,
   output logic fsr_out,
   output logic rxd_out
);
   initial begin
      bclk_out = 1'b0;
      fsx_out = 1'b0;
      fsr_out = 1'b0;
      rxd_out = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // four idle clocks first, so the mode level settles in the link domain
   task automatic frame(input logic dly, input logic late, input int fs_len,
      input logic [7:0] rx);
      int b;
      for (int r = -4; r < 14; r++) begin
         b = r - int'(dly);
         if (r == 0) begin
            fsx_out = !late;
            fsr_out = 1'b1;
         end
         #1 bclk_out = 1'b1;
         // idle data toggles, so a stale sample cannot pass
         rxd_out = (b >= 0 && b < 8) ? rx[7 - b] : ~rxd_out;
         #0.5;
         // late sync rises after the clock edge, away from the falling edge
         if (r == 0) fsx_out = 1'b1;
         #1.5 bclk_out = 1'b0;
         #1;
         if (r == 0) fsr_out = 1'b0;
         // a long sync outlasts the eighth bit to reach the other end cases
         if (r == fs_len - 1) fsx_out = 1'b0;
         #2;
      end
   endtask : frame
endmodule : pts_highway

// File: sim/pts_port_test.sv
// Purpose: self-checking bench for the pcm time-slot port
// Assumes: one byte each way per frame
// Notes: transmit pin sampled just after each rising bit-clock edge
`timescale 1ns/1ps
module pts_port_test;
   import pts_pkg::*;
   logic clock_in = 1'b0;
   logic nrst = 1'b0;
   logic dly = 1'b0;
   logic [7:0] txw = 8'h00;
   logic [7:0] rx;
   logic [7:0] tx_seen;
   logic bclk, transmit_frame_sync, receive_frame_sync, rxd, txd, oe, ind_n, rxv;
   pts_byte_type rxw;
   logic [7:0] rx_q[$];
   int tx_cnt, n_fail, n_compared;
   always #5 clock_in = ~clock_in;
   pts_highway hw (.bclk_out(bclk), .fsx_out(transmit_frame_sync), .fsr_out(receive_frame_sync),
      .rxd_out(rxd));
   pts_port uut (.CLOCK_IN(clock_in), .NRST_IN(nrst), .BIT_CLOCK_IN(bclk),
      .TRANSMIT_FRAME_SYNC_IN(transmit_frame_sync), .RECEIVE_FRAME_SYNC_IN(receive_frame_sync),
      .PCM_RECEIVE_INPUT_IN(rxd), .DELAYED_MODE_IN(dly), .TX_WORD_IN(txw),
      .PCM_TRANSMIT_OUTPUT_OUT(txd), .PCM_TRANSMIT_OE_OUT(oe),
      .TRANSMIT_SLOT_INDICATOR_N_OUT(ind_n), .RX_WORD_OUT(rxw),
      .RX_VALID_OUT(rxv));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      if (n_fail == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////
   always @(posedge bclk) begin
      #1;
      if (oe === 1'b1) begin
         tx_seen = {tx_seen[6:0], txd};
         tx_cnt++;
         check("indicator", {7'h00, ind_n}, 8'h00);
      end
   end
   // valid stands one cycle; mid-cycle look avoids the launch edge
   always @(negedge clock_in) begin
      if (rxv === 1'b1) begin
         if (rx_q.size() == 0) begin
            check("rx extra", 8'h01, 8'h00);
         end else begin
            check("rx word", rxw, rx_q.pop_front());
         end
      end
   end
   initial begin
      #20000;
      n_fail++;
      give_verdict();
   end
   initial begin
      void'($urandom(19));
      hw.frame(1'b0, 1'b0, 1, 8'h00);
      @(negedge clock_in);
      nrst = 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(negedge clock_in);
         dly = i[0];
         txw = (i == 2) ? 8'hFF : 8'($urandom);
         rx = (i == 3) ? 8'h00 : 8'($urandom);
         rx_q.push_back(rx);
         tx_cnt = 0;
         hw.frame(dly, i[1], i[2] ? 9 : 1, rx);
         repeat (6) @(negedge clock_in);
         check("tx bits", {4'h0, 4'(tx_cnt)}, 8'h08);
         check("tx word", tx_seen, txw);
         check("oe idle", {7'h00, oe}, 8'h00);
         check("ind idle", {7'h00, ind_n}, 8'h01);
      end
      check("rx left", 8'(rx_q.size()), 8'h00);
      give_verdict();
   end
endmodule : pts_port_test
